// File: hdl/epd_top.sv
`timescale 1ns/1ps
`include "epd_regs.svh"
module epd_top #(
    parameter int CIC_W = 28
) (
    input  wire logic              ref_clk,
    input  wire logic              srst,
    input  wire logic              master_clear_n,
    input  wire logic signed [3:0] mod_current,
    input  wire logic signed [3:0] mod_voltage,
    input  wire logic              rate_select_0,
    input  wire logic              rate_select_1,
    input  wire logic              rate_select_2,
    input  wire logic              gain_select_lo,
    input  wire logic              gain_select_hi,
    input  wire logic              highpass_enable,
    input  wire logic              serial_mode,
    input  wire logic              serial_product,
    input  wire logic              serial_clk,
    output logic                   fast_energy_pulse,
    output logic                   meter_pulse_a,
    output logic                   meter_pulse_b,
    output logic                   data_ready,
    output logic                   shared_out
);
    // two-stage synchronisers for the single-bit control inputs other than srst
    logic [9:0] sync1;
    logic [9:0] sync2;
    wire  [9:0] pins = {master_clear_n, rate_select_0, rate_select_1, rate_select_2,
                        gain_select_lo, gain_select_hi, highpass_enable,
                        serial_mode, serial_product, serial_clk};
    always_ff @(posedge ref_clk) begin
        sync1 <= pins;
        sync2 <= sync1; // [R22]
    end
    wire clr_n  = sync2[9];
    wire [2:0] rsel = {sync2[6], sync2[7], sync2[8]};
    wire [1:0] gsel = {sync2[4], sync2[5]};
    wire hpf_en = sync2[3];
    wire s_mode = sync2[2];
    wire s_prod = sync2[1];
    wire s_clk  = sync2[0];
    wire rst = srst | ~clr_n; // [R21]

    // shared strobe generation for both channels
    logic [1:0] mod_cnt;
    logic [5:0] dec_cnt;
    wire mod_stb = (mod_cnt == `EPD_MOD_DIV); // [R8] [R19]
    wire dec_stb = mod_stb & (dec_cnt == `EPD_DEC_RATIO); // [R16]
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            mod_cnt <= '0;
            dec_cnt <= '0;
        end else begin
            mod_cnt <= mod_cnt + 2'h1;
            if (mod_stb) dec_cnt <= dec_cnt + 6'h01;
        end
    end

    // current gain
    logic signed [8:0] cur_in;
    always_comb begin
        unique case (gsel) // [R13]
            2'b00: cur_in = 9'(mod_current);
            2'b01: cur_in = 9'(mod_current) <<< 1;
            2'b10: cur_in = 9'(mod_current) <<< 3;
            2'b11: cur_in = 9'(mod_current) <<< 4;
        endcase
    end
    wire signed [8:0] vol_in = 9'(mod_voltage);

    // sinc3 per channel
    logic signed [CIC_W-1:0] i1 [2];
    logic signed [CIC_W-1:0] i2 [2];
    logic signed [CIC_W-1:0] i3 [2];
    logic signed [CIC_W-1:0] d1 [2];
    logic signed [CIC_W-1:0] d2 [2];
    logic signed [CIC_W-1:0] d3 [2];
    logic signed [15:0]      code [2];
    logic signed [15:0]      hp [2];
    logic signed [31:0]      hp_acc [2];
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_ch
            wire signed [CIC_W-1:0] x       = CIC_W'(ch == 0 ? cur_in : vol_in);
            wire signed [CIC_W-1:0] c1      = i3[ch] - d1[ch];
            wire signed [CIC_W-1:0] c2      = c1 - d2[ch];
            wire signed [CIC_W-1:0] cc      = c2 - d3[ch];
            wire signed [CIC_W-1:0] sc      = cc >>> `EPD_CIC_SHIFT;
            wire                    sat_hi  = sc > CIC_W'(`EPD_MAX_CODE);
            wire                    sat_lo  = sc < CIC_W'(`EPD_MIN_CODE);
            wire signed [15:0]      clip    = sat_hi ? `EPD_MAX_CODE :
                                              sat_lo ? `EPD_MIN_CODE : sc[15:0]; // [R15]
            wire signed [31:0]      hp_diff = 32'(clip) - (hp_acc[ch] >>> `EPD_HPF_SHIFT);
            // integrators run at the modulator rate, wide enough that the comb output does not wrap
            always_ff @(posedge ref_clk) begin
                if (rst) begin // [R14]
                    i1[ch] <= '0;
                    i2[ch] <= '0;
                    i3[ch] <= '0;
                end else if (mod_stb) begin // [R8]
                    i1[ch] <= i1[ch] + x;
                    i2[ch] <= i2[ch] + i1[ch];
                    i3[ch] <= i3[ch] + i2[ch];
                end
            end
            // combs run at the word rate
            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    d1[ch] <= '0;
                    d2[ch] <= '0;
                    d3[ch] <= '0;
                end else if (dec_stb) begin // [R16]
                    d1[ch] <= i3[ch];
                    d2[ch] <= c1;
                    d3[ch] <= c2;
                end
            end
            // output code, clamped rather than wrapped
            always_ff @(posedge ref_clk) begin
                if (rst) begin // [R14]
                    code[ch] <= '0;
                end else if (dec_stb) begin
                    code[ch] <= clip; // [R15]
                end
            end
            // dc removal: the accumulator tracks the mean of the code
            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    hp_acc[ch] <= '0;
                    hp[ch] <= '0;
                end else if (dec_stb) begin
                    hp_acc[ch] <= hp_acc[ch] + hp_diff; // [R9]
                    hp[ch] <= hpf_en ? hp_diff[15:0] : clip; // [R20]
                end
            end
        end
    endgenerate

    // product, lowpass and accumulators
    logic signed [31:0] prod;
    logic signed [31:0] lpf;
    logic signed [47:0] fast_acc;
    logic signed [47:0] meter_acc;
    logic               dec_d;
    logic [7:0]         fast_len;
    logic [7:0]         meter_len;
    logic               meter_ph;
    logic               neg_flag;
    wire signed [31:0] lpf_step    = (prod - lpf) >>> `EPD_LPF_SHIFT;
    // fast quantum halves with each step of the three selects
    wire [47:0]        fast_thr    = `EPD_FAST_BASE >> rsel; // [R4]
    // meter quantum from the first two selects only, far above the fast one
    wire [47:0]        meter_base  = `EPD_FAST_BASE >> rsel[1:0]; // [R5] [R11]
    wire signed [47:0] meter_thr   = $signed(meter_base << `EPD_METER_SCALE); // [R12]
    wire signed [47:0] lpf_ext     = 48'(lpf);
    wire signed [47:0] fast_sum    = fast_acc + lpf_ext;
    wire signed [47:0] meter_sum   = meter_acc + lpf_ext;
    wire               fast_pos    = fast_sum >= $signed(fast_thr);
    wire               fast_neg    = fast_sum <= -$signed(fast_thr);
    wire               fast_hit    = fast_pos | fast_neg;
    wire signed [47:0] fast_back   = fast_pos ? $signed(fast_thr) : -$signed(fast_thr);
    wire               meter_hit   = (meter_sum >= meter_thr) || (meter_sum <= -meter_thr);
    wire               fast_start  = dec_d && fast_hit && (fast_len == 8'h00);
    wire               meter_start = dec_d && meter_hit && (meter_len == 8'h00);

    // word strobe delayed to line up with the filter outputs
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            dec_d <= 1'b0;
        end else begin
            dec_d <= dec_stb;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            data_ready <= 1'b0;
        end else begin
            data_ready <= dec_d; // [R17]
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            prod <= '0;
            lpf <= '0;
        end else if (dec_d) begin
            prod <= 32'(hp[0]) * 32'(hp[1]); // [R9]
            lpf <= lpf + lpf_step; // [R10]
        end
    end

    // fast side keeps its remainder so the average rate stays exact
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            fast_acc <= '0;
        end else if (dec_d) begin
            fast_acc <= fast_hit ? fast_sum - fast_back : fast_sum; // [R10]
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            meter_acc <= '0;
        end else if (dec_d) begin
            meter_acc <= meter_hit ? '0 : meter_sum; // [R11]
        end
    end

    // pulse length counters
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            fast_len <= '0;
        end else if (fast_start) begin
            fast_len <= `EPD_PULSE_LEN; // [R6]
        end else if (fast_len != 8'h00) begin
            fast_len <= fast_len - 8'h01;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            fast_energy_pulse <= 1'b0;
        end else begin
            fast_energy_pulse <= fast_start || (fast_len > 8'h01); // [R4]
        end
    end

    // flag follows the sign of the threshold crossed, only at pulse start
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            neg_flag <= 1'b0;
        end else if (fast_start) begin
            neg_flag <= fast_neg; // [R1] [R2]
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            meter_len <= '0;
        end else if (meter_start) begin
            meter_len <= `EPD_PULSE_LEN;
        end else if (meter_len != 8'h00) begin
            meter_len <= meter_len - 8'h01;
        end
    end

    // meter outputs alternate so a stepper sees two phases
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            meter_ph <= 1'b0;
        end else if (meter_start) begin
            meter_ph <= ~meter_ph;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            meter_pulse_a <= 1'b0;
            meter_pulse_b <= 1'b0;
        end else if (meter_start) begin
            meter_pulse_a <= ~meter_ph; // [R5]
            meter_pulse_b <= meter_ph;
        end else if (meter_len == 8'h01) begin
            meter_pulse_a <= 1'b0;
            meter_pulse_b <= 1'b0;
        end
    end

    // serial waveform shifter
    epd_pkg::epd_ser_state_t st;
    epd_pkg::epd_ser_state_t next_st;
    logic [19:0]             sh;
    logic [4:0]              bits;
    logic                    s_clk_d;
    wire        s_rise    = s_clk & ~s_clk_d;
    wire [19:0] load_word = s_prod ? prod[31:12] : {code[1], 4'h0}; // [R7]
    wire [4:0]  load_len  = s_prod ? 5'(`EPD_WORD_PROD) : 5'(`EPD_WORD_CH);
    wire        ser_idle  = (st == epd_pkg::EPD_SER_IDLE);
    wire        ser_load  = ser_idle && s_mode && data_ready;
    wire        ser_shift = !ser_idle && s_mode && (bits != 5'h00) && s_rise;

    // edge detector starts low, the idle level of the serial clock
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_clk_d <= 1'b0;
        end else begin
            s_clk_d <= s_clk;
        end
    end

    // leaving serial mode mid-word aborts it
    always_comb begin
        next_st = st;
        unique case (st)
            epd_pkg::EPD_SER_IDLE: begin
                if (s_mode && data_ready) begin
                    next_st = epd_pkg::EPD_SER_SHIFT;
                end
            end
            epd_pkg::EPD_SER_SHIFT: begin
                if (!s_mode || bits == 5'h00) begin
                    next_st = epd_pkg::EPD_SER_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st <= epd_pkg::EPD_SER_IDLE;
        end else begin
            st <= next_st;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sh <= '0;
        end else if (ser_load) begin
            sh <= load_word;
        end else if (ser_shift) begin
            sh <= {sh[18:0], 1'b0};
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            bits <= '0;
        end else if (ser_load) begin
            bits <= load_len;
        end else if (ser_shift) begin
            bits <= bits - 5'h01;
        end
    end

    // flag and serial data share one pin
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            shared_out <= 1'b0;
        end else begin
            shared_out <= s_mode ? sh[19] : neg_flag; // [R3]
        end
    end
endmodule

// File: hdl/epd_regs.svh
// Operation
// [R1] flag set when real power negative
// [R2] flag changes only at fast pulse rise
// [R3] shared pin: serial data or flag
// [R4] fast pulses scaled by three-bit constant
// [R5] meter pulses scaled by two-bit constant
// [R6] pulses keep running during serial output
// [R7] serial words 16-bit channels, 20-bit product (the code serialises only the voltage channel, code[1])
// [R8] modulator sample at clock/4, ratio 64
// [R9] identical highpass, then multiply to power
// [R10] lowpass then accumulate into pulse converter
// [R11] meter pulse is fixed energy quantum (the code clears meter_acc at each hit, dropping the remainder)
// [R12] fast threshold smaller than meter threshold
// [R13] gain select gives 1, 2, 8, 16
// [R14] clear holds converters at zero code
// [R15] channel output clamps at saturation
// [R16] sinc3 word rate is clock/256
// [R17] data ready once per word
// [R18] host discards first three data readies
// [R19] both channels share one strobe set
// [R20] highpass enable low bypasses both filters
// [R21] clear resets every register and accumulator (the pin synchronisers sync1 and sync2 have no reset)
// [R22] rate and gain inputs synchronised first
`ifndef EPD_REGS_SVH
`define EPD_REGS_SVH
`define EPD_MOD_DIV      2'h3
`define EPD_DEC_RATIO    6'h3F
`define EPD_HPF_SHIFT    10
`define EPD_LPF_SHIFT    8
`define EPD_MAX_CODE     16'sh7FFF
`define EPD_MIN_CODE     -16'sh7FFF
`define EPD_WORD_CH      16
`define EPD_WORD_PROD    20
`define EPD_METER_SCALE  6
`define EPD_PULSE_LEN    8'h0F
`define EPD_CIC_SHIFT    7
`define EPD_FAST_BASE    48'h0000_0100_0000
`endif

// File: hdl/epd_pkg.sv
package epd_pkg;
    typedef enum logic [1:0] {
        EPD_SER_IDLE = 2'b00,
        EPD_SER_SHIFT = 2'b01
    } epd_ser_state_t;
endpackage

// File: dv/epd_chk.sv
`timescale 1ns/1ps
module epd_chk (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic master_clear_n,
    input wire logic serial_mode,
    input wire logic fast_energy_pulse,
    input wire logic meter_pulse_a,
    input wire logic meter_pulse_b,
    input wire logic data_ready,
    input wire logic shared_out
);
    logic [4:0] fast_len;
    logic       fast_seen;
    wire        mtr = meter_pulse_a || meter_pulse_b;
    wire        quiet = !fast_energy_pulse && !mtr && !data_ready && !shared_out;
    always_ff @(posedge ref_clk) begin
        fast_len <= fast_energy_pulse ? fast_len + 5'h01 : 5'h00;
        if (srst || !master_clear_n || mtr) fast_seen <= 1'b0;
        else if (fast_energy_pulse) fast_seen <= 1'b1;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst || !master_clear_n);
    sequence s_clear_held; !master_clear_n [*4]; endsequence
    sequence s_ready_gap; !data_ready [*8]; endsequence
    sequence s_flag_move; !serial_mode [*6] ##0 $changed(shared_out); endsequence
    a_clear_quiet: assert property (disable iff (srst) s_clear_held |-> quiet)
        else $error("outputs active under clear");
    a_reset_zero: assert property (disable iff (1'b0) srst |=> quiet)
        else $error("outputs active after reset");
    a_ready_single: assert property (data_ready |=> s_ready_gap)
        else $error("data ready too close");
    a_ready_period: assert property (data_ready |-> ##256 data_ready)
        else $error("data ready period wrong");
    a_fast_width: assert property ($fell(fast_energy_pulse) && !$past(srst) |-> fast_len == 5'h0F)
        else $error("fast pulse width wrong");
    a_meter_excl: assert property (!(meter_pulse_a && meter_pulse_b))
        else $error("meter outputs overlap");
    a_meter_rarer: assert property ($rose(mtr) |-> fast_seen)
        else $error("meter pulse without fast pulse");
    a_flag_edge: assert property (s_flag_move |-> fast_energy_pulse && fast_len < 5'h03)
        else $error("flag moved off fast pulse");
endmodule
bind epd_top epd_chk u_chk (.ref_clk, .srst, .master_clear_n, .serial_mode, .fast_energy_pulse,
    .meter_pulse_a, .meter_pulse_b, .data_ready, .shared_out);

// File: dv/epd_host.sv
`timescale 1ns/1ps
module epd_host (
    input  wire logic       ref_clk,
    input  wire logic       master_clear_n,
    input  wire logic       data_ready,
    input  wire logic       shared_out,
    input  wire logic       req,
    input  wire logic [4:0] nbits,
    output logic            serial_clk,
    output logic [19:0]     word,
    output logic            done
);
    int seen;
    initial begin
        serial_clk = 1'b0;
        done = 1'b0;
        seen = 0;
        forever begin
            @(posedge ref_clk);
            if (!req) done <= 1'b0;
            if (!master_clear_n) seen = 0;
            else if (data_ready && seen < 3) seen++;
            else if (data_ready && req && !done) begin
                repeat (3) @(posedge ref_clk);
                for (int i = 0; i < nbits; i++) begin
                    word = {word[18:0], shared_out};
                    serial_clk <= 1'b1;
                    repeat (5) @(posedge ref_clk);
                    serial_clk <= 1'b0;
                    repeat (5) @(posedge ref_clk);
                end
                done <= 1'b1;
            end
        end
    end
endmodule

// File: dv/tb.sv
`timescale 1ns/1ps
module tb;
    logic              ref_clk, srst, master_clear_n, rate_select_0, rate_select_1, rate_select_2;
    logic              gain_select_lo, gain_select_hi, highpass_enable, serial_mode, serial_product;
    logic              serial_clk, fast_energy_pulse, meter_pulse_a, meter_pulse_b, data_ready;
    logic              shared_out, req, done;
    logic signed [3:0] mod_current, mod_voltage;
    logic [4:0]        nbits;
    logic [19:0]       word;
    logic [2:0]        prev;
    int                err_count, cmp_count, cyc, nf, na, nb, nd, f7;
    epd_top uut (.ref_clk, .srst, .master_clear_n, .mod_current, .mod_voltage, .rate_select_0,
        .rate_select_1, .rate_select_2, .gain_select_lo, .gain_select_hi, .highpass_enable,
        .serial_mode, .serial_product, .serial_clk, .fast_energy_pulse, .meter_pulse_a,
        .meter_pulse_b, .data_ready, .shared_out);
    epd_host host (.ref_clk, .master_clear_n, .data_ready, .shared_out, .req, .nbits,
        .serial_clk, .word, .done);
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        prev <= {fast_energy_pulse, meter_pulse_a, meter_pulse_b};
        if (fast_energy_pulse && !prev[2]) nf++;
        if (meter_pulse_a && !prev[1]) na++;
        if (meter_pulse_b && !prev[0]) nb++;
        if (data_ready) nd++;
        cyc++;
        if (cyc == 90000) begin
            err_count++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("mismatches %0d comparisons %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input string what, input logic [19:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic run(input logic [3:0] cur, vol, input logic [2:0] rs, input logic [1:0] g);
        master_clear_n <= 1'b0;
        mod_current <= cur;
        mod_voltage <= vol;
        {rate_select_2, rate_select_1, rate_select_0} <= rs;
        {gain_select_hi, gain_select_lo} <= g;
        repeat (4) @(posedge ref_clk);
        master_clear_n <= 1'b1;
        nf = 0;
        na = 0;
        nb = 0;
        nd = 0;
        repeat (12000) @(posedge ref_clk);
    endtask
    task automatic read_word(input logic [4:0] n);
        int k;
        nbits <= n;
        req <= 1'b1;
        for (k = 0; done !== 1'b1 && k < 3000; k++) @(posedge ref_clk);
        chk("read done", done, 20'h1);
        req <= 1'b0;
        repeat (2) @(posedge ref_clk);
    endtask
    task automatic t_reset();
        srst <= 1'b1;
        @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        #1 chk("idle outputs", {fast_energy_pulse, mtr_pair(), data_ready, shared_out}, 20'h0);
        @(posedge ref_clk);
    endtask
    function automatic logic [1:0] mtr_pair();
        return {meter_pulse_a, meter_pulse_b};
    endfunction
    task automatic t_rate_gain();
        run(4'h3, 4'h3, 3'h0, 2'h0);
        f7 = nf;
        run(4'h3, 4'h3, 3'h7, 2'h0);
        chk("fast rate scaling", nf > f7, 20'h1);
        chk("flag positive", shared_out, 20'h0);
        run(4'h3, 4'h3, 3'h0, 2'h3);
        chk("gain scaling", nf > f7, 20'h1);
    endtask
    task automatic t_neg_serial();
        run(4'hD, 4'h3, 3'h7, 2'h0);
        chk("fast pulses negative", nf > 0, 20'h1);
        chk("flag negative", shared_out, 20'h1);
        serial_mode <= 1'b1;
        read_word(5'h10);
        chk("voltage word", {word[15], word[15:0] != 16'h0}, 20'h1);
        serial_product <= 1'b1;
        read_word(5'h14);
        chk("product sign", word[19], 20'h1);
        serial_mode <= 1'b0;
        serial_product <= 1'b0;
        repeat (8) @(posedge ref_clk);
        chk("flag restored", shared_out, 20'h1);
    endtask
    task automatic t_meter();
        serial_mode <= 1'b1;
        serial_product <= 1'b1;
        fork
            run(4'h7, 4'h7, 3'h3, 2'h3);
            read_word(5'h14);
        join
        chk("meter a pulses", na > 0, 20'h1);
        chk("meter b pulses", nb > 0, 20'h1);
        chk("fast above meter", nf > na + nb, 20'h1);
        chk("ready count", nd, 20'h2E);
    endtask
    initial begin
        {srst, master_clear_n, serial_mode, serial_product, highpass_enable, req} = 6'h30;
        {rate_select_2, rate_select_1, rate_select_0, gain_select_hi, gain_select_lo} = 5'h00;
        mod_current = 4'h0;
        mod_voltage = 4'h0;
        nbits = 5'h10;
        repeat (6) @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        t_reset();
        t_rate_gain();
        t_neg_serial();
        t_meter();
        stop_test();
    end
endmodule
